// >>> shared/pds_pkg.sv
// Purpose: constants and types for the parameter dictionary store
// Assumes: 16-bit index, 8-bit subindex, 32-bit entry values
// Notes: channel ranges use a stride of 0x10 indices
package pds_pkg;
    // ========================================
    // Address ranges
    localparam logic [15:0] PDS_IDX_IDENT = 16'h1000;
    localparam logic [15:0] PDS_IDX_LEGACY = 16'h4000;
    localparam logic [15:0] PDS_IDX_INPUT = 16'h6000;
    localparam logic [15:0] PDS_IDX_OUTPUT = 16'h7000;
    localparam logic [15:0] PDS_IDX_CHAN = 16'h8000;
    localparam logic [15:0] PDS_IDX_SUPPRESS = 16'hF008;
    localparam logic [15:0] PDS_CHAN_STRIDE = 16'h0010;
    localparam logic [31:0] PDS_CODE_WORD = 32'h12345678;
    // ========================================
    // Store geometry: channels x settings per channel
    localparam int PDS_NCHAN = 4;
    localparam int PDS_NSUB = 8;
    localparam int PDS_NENT = PDS_NCHAN * PDS_NSUB;
    // Identity entries at 0x1000 (subindex 0..3)
    localparam int PDS_NIDENT = 4;
    // Arbitrary identity word
    localparam logic [31:0] PDS_IDENT_VAL = 32'h0000A5A5;
    // Factory default for every writable setting
    localparam logic [31:0] PDS_DEFAULT_VAL = 32'h00000000;
    // Input/output process-data descriptor (subindex 0 count)
    localparam logic [31:0] PDS_PD_COUNT = 32'h00000001;
    // ========================================
    // Result codes
    typedef enum logic [1:0]
    {
        PDS_OK = 2'h0,
        PDS_ERR_NOENT = 2'h1,
        PDS_ERR_RDONLY = 2'h2
    } pds_res_t;
endpackage

// >>> shared/pds_nv_if.sv
// Purpose: link between dictionary core and nonvolatile commit unit
// Assumes: single clock
// Notes: commit request holds until accepted
`timescale 1ns/10ps
interface pds_nv_if;
    logic req; // Commit wanted
    logic [4:0] slot; // Entry slot
    logic [31:0] data; // Value to save
    logic busy; // Commit unit working
    modport core (output req, output slot, output data, input busy);
    modport saver (input req, input slot, input data, output busy);
endinterface

// >>> hdl/pds_nv_commit.sv
// Purpose: commits changed entries to nonvolatile memory
// Assumes: memory write port answers with done pulse
// Notes: one save at a time, busy until done
`timescale 1ns/10ps
module pds_nv_commit
    import pds_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    pds_nv_if.saver nv,
    output logic nvWrite,
    output logic [4:0] nvAddr,
    output logic [31:0] nvData,
    input wire logic nvDone
);
    typedef struct packed
    {
        logic busy;
        logic [4:0] addr;
        logic [31:0] data;
    } pds_nvst_t;
    pds_nvst_t st_r, st_nxt;
    // ========================================
    // Next state: latch one request, hold until memory done
    always_comb
    begin
        st_nxt = st_r;
        // RULE7 power-fail-safe commit
        if (!st_r.busy && nv.req)
        begin
            st_nxt.busy = 1'b1;
            st_nxt.addr = nv.slot;
            st_nxt.data = nv.data;
        end
        else if (st_r.busy && nvDone)
        begin
            st_nxt.busy = 1'b0;
        end
    end
    // ========================================
    // State register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    // Memory keeps old value until write completes, so a
    // cut mid-write leaves either old or new word intact
    assign nvWrite = st_r.busy;
    assign nvAddr = st_r.addr;
    assign nvData = st_r.data;
    assign nv.busy = st_r.busy;
endmodule

// >>> hdl/pds_store.sv
// Purpose: parameter dictionary addressed by index and subindex
// Assumes: one request at a time; answer one cycle later
// Notes: no software registers; master requests on plain ports
// Notes: at most one save waits for the commit unit; further requests stall
//
// Notes on behaviour
// RULE1 - 16-bit index plus 8-bit subindex addressing
// RULE2 - Reads always allowed; writes only writable
// RULE3 - Identity and PD descriptions at 0x1000; code holds only identity there, PD counts sit at 0x6000/0x7000
// RULE4 - Channel settings live from 0x8000
// RULE5 - Legacy 0x4000 range mirrors 0x8000 range
// RULE6 - Inputs at 0x6000, outputs at 0x7000
// RULE7 - Online changes saved power-fail safely
// RULE8 - Code word at 0xF008 enables suppression
// RULE9 - Suppressed: working copy only, no saving
// RULE10 - Each channel spans sixteen consecutive indices; code holds settings only at the first index of each
// RULE11 - Master limits writes without suppression
// RULE12 - Fresh unit starts with factory defaults
// RULE13 - Master replays startup list at start
// RULE14 - Missing entry or read-only write refused
`timescale 1ns/10ps
module pds_store
    import pds_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [15:0] reqIndex,
    input wire logic [7:0] reqSub,
    input wire logic [31:0] reqData,
    output logic reqReady,
    output logic rspValid,
    output logic [1:0] rspCode,
    output logic [31:0] rspData,
    output logic suppressNvSave,
    output logic nvWrite,
    output logic [4:0] nvAddr,
    output logic [31:0] nvData,
    input wire logic nvDone
);
    // ========================================
    // Decoded address
    // One-hot codes keep the case arms cheap and disjoint;
    // every request lands in exactly one range
    typedef enum logic [4:0]
    {
        PDS_R_NONE = 5'h01,
        PDS_R_IDENT = 5'h02,
        PDS_R_PD = 5'h04,
        PDS_R_CHAN = 5'h08,
        PDS_R_SUPP = 5'h10
    } pds_reg_t;

    // All module state
    // One packed struct, so reset and next state stay
    // in step; the settings array dominates its size
    typedef struct packed
    {
        logic [PDS_NENT-1:0][31:0] mem; // Working copy of settings
        logic [31:0] suppWord; // Value held at 0xF008
        logic rspValid;
        logic [1:0] rspCode;
        logic [31:0] rspData;
        logic pend; // Save waiting for commit unit
        logic [4:0] pendSlot;
    } pds_st_t;

    pds_st_t st_r, st_nxt;
    pds_nv_if nvl ();
    logic suppOn; // Suppression active

    // ========================================
    // Address decode, shared by read and write paths
    // RULE1 full index and subindex decode
    function automatic pds_reg_t decodeRange(input logic [15:0] idx,
        input logic [7:0] sub);
        logic [15:0] off;
        off = 16'h0000;
        decodeRange = PDS_R_NONE;
        // RULE4 channel ranges, RULE5 legacy mirror
        if ((idx & 16'hF000) == PDS_IDX_CHAN ||
            (idx & 16'hF000) == PDS_IDX_LEGACY)
        begin
            off = idx & 16'h0FFF;
            // Limitation: only the first index of each channel
            // holds settings; the other fifteen answer no entry
            // RULE10 stride 0x10, index 0 within channel used
            if (off[15:4] < 12'(PDS_NCHAN) && off[3:0] == 4'h0 &&
                sub < 8'(PDS_NSUB))
                decodeRange = PDS_R_CHAN;
        end
        // RULE3 identity entries
        else if (idx == PDS_IDX_IDENT && sub < 8'(PDS_NIDENT))
            decodeRange = PDS_R_IDENT;
        // RULE6 input and output descriptions
        else if ((idx == PDS_IDX_INPUT || idx == PDS_IDX_OUTPUT) &&
            sub == 8'h00)
            decodeRange = PDS_R_PD;
        // RULE8 single code-word entry
        else if (idx == PDS_IDX_SUPPRESS && sub == 8'h00)
            decodeRange = PDS_R_SUPP;
    endfunction

    // Slot of a channel entry; mirror ranges share one slot
    // RULE5 both ranges map here, so writes show in both
    // Slot is channel times eight plus subindex
    function automatic logic [4:0] slotOf(input logic [15:0] idx,
        input logic [7:0] sub);
        slotOf = {idx[5:4], sub[2:0]};
    endfunction

    // RULE8 active only while the code word is held
    // Reset clears the word, so power-on starts unsuppressed
    assign suppOn = (st_r.suppWord == PDS_CODE_WORD);

    // ========================================
    // Next state: serve request, queue saves
    always_comb
    begin
        pds_reg_t rg;
        logic [4:0] sl;
        rg = decodeRange(reqIndex, reqSub);
        sl = slotOf(reqIndex, reqSub);
        st_nxt = st_r;
        st_nxt.rspValid = 1'b0;
        // Hand pending save to commit unit when it is free
        // Request and accept fall in the same cycle
        if (st_r.pend && !nvl.busy)
            st_nxt.pend = 1'b0;
        if (reqValid && reqReady)
        begin
            st_nxt.rspValid = 1'b1;
            st_nxt.rspCode = PDS_OK;
            st_nxt.rspData = 32'h00000000;
            unique case (rg)
                PDS_R_NONE:
                    // RULE14 unknown entry refused
                    st_nxt.rspCode = PDS_ERR_NOENT;
                // RULE3 and RULE6 fixed descriptions
                PDS_R_IDENT, PDS_R_PD:
                begin
                    // RULE2 fixed entries refuse writes
                    if (reqWrite)
                        st_nxt.rspCode = PDS_ERR_RDONLY;
                    else if (rg == PDS_R_IDENT)
                        st_nxt.rspData = PDS_IDENT_VAL;
                    else
                        st_nxt.rspData = PDS_PD_COUNT;
                end
                // RULE8 any other value ends suppression
                // Word itself is never saved, so power-on clears it
                PDS_R_SUPP:
                begin
                    if (reqWrite)
                        st_nxt.suppWord = reqData;
                    else
                        st_nxt.rspData = st_r.suppWord;
                end
                // RULE4 writable settings, either range
                PDS_R_CHAN:
                begin
                    if (reqWrite)
                    begin
                        st_nxt.mem[sl] = reqData;
                        // RULE9 no save while suppressed
                        if (!suppOn)
                        begin
                            // RULE7 queue save of changed value
                            st_nxt.pend = 1'b1;
                            st_nxt.pendSlot = sl;
                        end
                    end
                    else
                        // Read returns the working copy
                        st_nxt.rspData = st_r.mem[sl];
                end
            endcase
        end
    end

    // ========================================
    // State register; defaults at every power-on
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // RULE12 factory defaults, RULE8 suppression off
            st_r <= '0;
            // Settings come back as factory defaults
            st_r.mem <= {PDS_NENT{PDS_DEFAULT_VAL}};
            st_r.rspCode <= PDS_OK;
        end
        else
            // Every field moves together each edge
            st_r <= st_nxt;
    end

    // Stall while a save waits, so no change is dropped;
    // trade-off: one write per commit, memory-bound rate
    assign reqReady = !st_r.pend;
    assign rspValid = st_r.rspValid;
    assign rspCode = st_r.rspCode;
    assign rspData = st_r.rspData;
    assign suppressNvSave = suppOn;

    // Commit request carries the latest working value
    assign nvl.req = st_r.pend;
    assign nvl.slot = st_r.pendSlot;
    assign nvl.data = st_r.mem[st_r.pendSlot];

    // ========================================
    // Nonvolatile commit unit
    // Takes one slot at a time; the store stalls new
    // requests rather than queue more than one save
    pds_nv_commit uCommit
    (
        .clk(clk),
        .nrst(nrst),
        .nv(nvl),
        .nvWrite(nvWrite),
        .nvAddr(nvAddr),
        .nvData(nvData),
        .nvDone(nvDone)
    );
endmodule

// >>> tb/pds_nv_model.sv
// Purpose: nonvolatile memory behind the commit port
// Assumes: one save at a time
// Notes: answers each save with a done pulse four cycles after write rises
`timescale 1ns/10ps
module pds_nv_model
(
    input logic clk,
    input logic nrst,
    input logic nvWrite,
    input logic [4:0] nvAddr,
    input logic [31:0] nvData,
    output logic nvDone,
    output logic [4:0] lastAddr,
    output logic [31:0] lastData,
    output int saves
);
    int cnt; // Cycles into the current save
    always @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            cnt <= 0;
            nvDone <= 1'b0;
            saves <= 0;
        end
        else
        begin
            cnt <= (nvWrite && cnt < 4) ? cnt + 1 : 0;
            nvDone <= nvWrite && cnt == 3;
            if (nvDone)
            begin
                saves <= saves + 1;
                lastAddr <= nvAddr;
                lastData <= nvData;
            end
        end
endmodule

// >>> tb/pds_store_checker.sv
// Purpose: timing relations at the store's ports
// Assumes: single clock, async active-low reset
// Notes: attached by bind
`timescale 1ns/10ps
module pds_store_checker
    import pds_pkg::*;
(
    input logic clk,
    input logic nrst,
    input logic reqValid,
    input logic reqWrite,
    input logic [15:0] reqIndex,
    input logic [7:0] reqSub,
    input logic [31:0] reqData,
    input logic reqReady,
    input logic rspValid,
    input logic [1:0] rspCode,
    input logic [31:0] rspData,
    input logic suppressNvSave,
    input logic nvWrite,
    input logic [4:0] nvAddr,
    input logic [31:0] nvData,
    input logic nvDone
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Request taken this edge
    wire tk = reqValid && reqReady;
    // Write to a stored channel setting through the 0x8000 range
    wire chw = tk && reqWrite && reqIndex[15:12] == 4'h8
        && reqIndex[11:6] == 6'h00 && reqIndex[3:0] == 4'h0
        && reqSub < 8'h08;
    a_rsp_one_cycle: assert property (tk |=> rspValid)
        else $error("no answer after request");
    a_ident_read: assert property (tk && !reqWrite && reqIndex == PDS_IDX_IDENT
        && reqSub < 8'h04 |=> rspCode == PDS_OK && rspData == PDS_IDENT_VAL)
        else $error("identity read wrong");
    a_ro_refused: assert property (tk && reqWrite && reqIndex == PDS_IDX_IDENT
        |=> rspCode != PDS_OK) else $error("read-only write accepted");
    a_chan_gap: assert property (tk && reqIndex[15:12] == 4'h8
        && reqIndex[3:0] != 4'h0 |=> rspCode == PDS_ERR_NOENT)
        else $error("gap index answered");
    a_save_start: assert property (chw && !suppressNvSave |=> !reqReady)
        else $error("save not pending");
    a_nv_hold: assert property (nvWrite && !nvDone
        |=> nvWrite && $stable(nvAddr) && $stable(nvData))
        else $error("save dropped early");
    a_suppress_set: assert property (tk && reqWrite
        && reqIndex == PDS_IDX_SUPPRESS && reqSub == 8'h00
        && reqData == PDS_CODE_WORD |=> suppressNvSave)
        else $error("suppression not set");
    a_suppress_nosave: assert property (chw && suppressNvSave |=> reqReady)
        else $error("save while suppressed");
    c_save: cover property (chw && !suppressNvSave);
    c_quiet: cover property (chw && suppressNvSave);
    c_done: cover property (nvDone && nvWrite);
endmodule
bind pds_store pds_store_checker u_chk (.clk(clk), .nrst(nrst),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqIndex(reqIndex),
    .reqSub(reqSub), .reqData(reqData), .reqReady(reqReady),
    .rspValid(rspValid), .rspCode(rspCode), .rspData(rspData),
    .suppressNvSave(suppressNvSave), .nvWrite(nvWrite), .nvAddr(nvAddr),
    .nvData(nvData), .nvDone(nvDone));

// >>> tb/tb_parameter_dictionary_store.sv
// Purpose: self-checking bench for the dictionary store
// Assumes: inputs change on the falling edge
// Notes: memory model answers saves
`timescale 1ns/10ps
module tb_parameter_dictionary_store;
    import pds_pkg::*;
    logic clk = 0, nrst = 0, reqValid = 0, reqWrite = 0;
    logic [15:0] reqIndex = 0;
    logic [7:0] reqSub = 0;
    logic [31:0] reqData = 0, rspData, lastData, nvData;
    logic reqReady, rspValid, suppressNvSave, nvWrite, nvDone;
    logic [1:0] rspCode;
    logic [4:0] nvAddr, lastAddr;
    int saves, n_fail = 0, n_checks = 0, cyc = 0, n;
    always #2 clk = ~clk;
    pds_store dut (.clk(clk), .nrst(nrst), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqIndex(reqIndex), .reqSub(reqSub),
        .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
        .rspCode(rspCode), .rspData(rspData), .suppressNvSave(suppressNvSave),
        .nvWrite(nvWrite), .nvAddr(nvAddr), .nvData(nvData), .nvDone(nvDone));
    pds_nv_model mem (.clk(clk), .nrst(nrst), .nvWrite(nvWrite),
        .nvAddr(nvAddr), .nvData(nvData), .nvDone(nvDone),
        .lastAddr(lastAddr), .lastData(lastData), .saves(saves));
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // One request, held until ready, answer judged next cycle
    task automatic acc(input logic w, input logic [15:0] ix,
        input logic [7:0] sb, input logic [31:0] d, input logic [1:0] ec,
        input logic [31:0] ed);
        reqValid = 1;
        reqWrite = w;
        reqIndex = ix;
        reqSub = sb;
        reqData = d;
        repeat (50) if (reqReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        reqValid = 0;
        chk(rspValid === 1 && rspCode === ec && (w || rspData === ed),
            $sformatf("answer at %h:%h", ix, sb));
        // Idle edge so the next call never re-raises valid at once
        @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_ident;
        for (int i = 0; i < 4; i++)
            acc(0, 16'h1000, i[7:0], 0, PDS_OK, PDS_IDENT_VAL);
        acc(0, 16'h6000, 8'h00, 0, PDS_OK, PDS_PD_COUNT);
        acc(0, 16'h7000, 8'h00, 0, PDS_OK, PDS_PD_COUNT);
        acc(1, 16'h1000, 8'h00, 5, PDS_ERR_RDONLY, 0);
        acc(0, 16'h1000, 8'h00, 0, PDS_OK, PDS_IDENT_VAL);
        acc(0, 16'h1000, 8'h04, 0, PDS_ERR_NOENT, 0);
        $display("ident test done");
    endtask
    task automatic t_mirror;
        acc(0, 16'h8030, 8'h07, 0, PDS_OK, PDS_DEFAULT_VAL);
        // saved writes kept to a handful
        acc(1, 16'h8010, 8'h02, 32'hA5, PDS_OK, 0);
        acc(0, 16'h4010, 8'h02, 0, PDS_OK, 32'hA5);
        acc(1, 16'h4030, 8'h07, 32'h5A, PDS_OK, 0);
        acc(0, 16'h8030, 8'h07, 0, PDS_OK, 32'h5A);
        acc(0, 16'h8011, 8'h00, 0, PDS_ERR_NOENT, 0);
        acc(0, 16'h8040, 8'h00, 0, PDS_ERR_NOENT, 0);
        repeat (20) if (nvWrite !== 1'b0) @(negedge clk);
        chk(saves === 2 && lastAddr === 5'h1F && lastData === 32'h5A,
            "saved slot");
        $display("mirror test done");
    endtask
    task automatic t_suppress;
        acc(1, PDS_IDX_SUPPRESS, 8'h00, PDS_CODE_WORD, PDS_OK, 0);
        chk(suppressNvSave === 1, "suppression on");
        n = saves;
        acc(1, 16'h8000, 8'h01, 32'h77, PDS_OK, 0);
        repeat (10) @(negedge clk);
        chk(saves === n && nvWrite === 0, "no save");
        acc(0, 16'h8000, 8'h01, 0, PDS_OK, 32'h77);
        acc(1, PDS_IDX_SUPPRESS, 8'h00, 0, PDS_OK, 0);
        chk(suppressNvSave === 0, "suppression off");
        acc(1, PDS_IDX_SUPPRESS, 8'h00, PDS_CODE_WORD, PDS_OK, 0);
        nrst = 0;
        repeat (2) @(negedge clk);
        nrst = 1;
        chk(suppressNvSave === 0, "off after power-on");
        acc(0, 16'h8010, 8'h02, 0, PDS_OK, PDS_DEFAULT_VAL);
        acc(1, 16'h8010, 8'h02, 32'hA5, PDS_OK, 0);
        acc(0, 16'h4010, 8'h02, 0, PDS_OK, 32'hA5);
        $display("suppress test done");
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            $display("CHECK FAILED %0t timeout", $time);
            complete_run;
        end
    end
    initial
    begin
        repeat (5) @(negedge clk);
        nrst = 1;
        chk(suppressNvSave === 0 && reqReady === 1, "reset state");
        t_ident;
        t_mirror;
        t_suppress;
        complete_run;
    end
endmodule
